// file: shared/ccc_pkg.sv
// Constants, register map and mode-word layout of the counter channel configuration block
package ccc_pkg;

   // Bank shape
   localparam int CCC_CHANNELS = 6;
   localparam int CCC_PAIRS = 3;
   localparam int CCC_CORE_W = 24;
   localparam logic [2:0] CCC_FIRST_B = 3'h3;

   // Register byte offsets
   localparam logic [7:0] CCC_OFS_CHAN = 8'h00;
   localparam logic [7:0] CCC_OFS_MODE = 8'h04;
   localparam logic [7:0] CCC_OFS_GATE = 8'h08;
   localparam logic [7:0] CCC_OFS_PRELOAD = 8'h0c;
   localparam logic [7:0] CCC_OFS_LOADTRIG = 8'h10;
   localparam logic [7:0] CCC_OFS_STATUS = 8'h14;
   localparam logic [7:0] CCC_OFS_COUNT = 8'h18;
   localparam logic [7:0] CCC_OFS_LATCH = 8'h1c;

   // Mode word field positions
   localparam int CCC_F_INTSRC = 0;
   localparam int CCC_F_LATCH = 2;
   localparam int CCC_F_LOADSRC = 4;
   localparam int CCC_F_INDXSRC = 6;
   localparam int CCC_F_INDXPOL = 7;
   localparam int CCC_F_CLKSRC = 8;
   localparam int CCC_F_CLKPOL = 10;
   localparam int CCC_F_CLKMULT = 11;
   localparam int CCC_F_CLKENAB = 13;
   localparam logic [15:0] CCC_MODE_MASK = 16'h3fff;

   // Status word field positions
   localparam int CCC_ST_ERR = 0;
   localparam int CCC_ST_IDX = 8;
   localparam int CCC_ST_OVF = 16;

   // Field codes
   localparam logic [1:0] CCC_IRQ_SOURCE_OFF = 2'h0;
   localparam logic [1:0] CCC_LOAD_ON_OWN_INDEX = 2'h0;
   localparam logic [1:0] CCC_LOAD_ON_OWN_OVERFLOW = 2'h1;
   localparam logic [1:0] CCC_LOAD_OFF_ALTERNATE_CODE = 2'h2;
   localparam logic [1:0] CCC_LOAD_ON_PAIRED_OVERFLOW = 2'h2;
   localparam logic [1:0] CCC_LOAD_DISABLED = 2'h3;
   localparam logic [1:0] CCC_CLKSRC_EXTENDER = 2'h3;
   localparam logic [1:0] CCC_CLKMULT_1X = 2'h2;
   localparam logic CCC_COUNT_GATE_ALWAYS = 1'b0;
   localparam logic CCC_COUNT_GATE_BY_INDEX = 1'b1;

   // Limits of legal write values
   localparam logic [15:0] CCC_MAX_CHAN = 16'h0005;
   localparam logic [15:0] CCC_MAX_LOAD = 16'h0003;

   // Reset values
   localparam logic [15:0] CCC_MODE_RESET = 16'h1030;
   localparam logic [2:0] CCC_CHAN_RESET = 3'h0;
   localparam logic [1:0] CCC_LATCH_RESET = 2'h0;

endpackage

// file: rtl/ccc_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module ccc_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Asynchronous in, synchronised out
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   import ccc_pkg::*;

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } ccc_sync_state_type;

   ccc_sync_state_type st_reg, st_next;

   if (W < 1) begin : g_chk
      $error("ccc_sync width must be at least one");
   end

   // First stage feeds only the second, to contain metastability
   always_comb begin
      st_next.s1 = async_i;
      st_next.s2 = st_reg.s1;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sync_o = st_reg.s2;
endmodule

// file: rtl/ccc_core.sv
// One counter core with preload transfer, load trigger decode and event capture
`timescale 1ns/10ps
module ccc_core #(
   parameter int CORE_W = ccc_pkg::CCC_CORE_W,
   parameter bit IS_B = 1'b0
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Synchronised pins
   input wire logic index_i,
   input wire logic step_i,
   // Configuration
   input wire logic indx_soft_i,
   input wire logic indx_neg_i,
   input wire logic gate_by_index_i,
   input wire logic [1:0] load_sel_i,
   input wire logic [CORE_W-1:0] preload_i,
   input wire logic pair_ovf_i,
   input wire logic cap_clr_i,
   // State out
   output logic ovf_o,
   output logic idx_cap_o,
   output logic ovf_cap_o,
   output logic [CORE_W-1:0] count_o,
   output logic [CORE_W-1:0] latch_o
);
   import ccc_pkg::*;

   typedef struct packed {
      logic [CORE_W-1:0] count;
      logic [CORE_W-1:0] latch;
      logic idx_prev;
      logic step_prev;
      logic ovf;
      logic idx_cap;
      logic ovf_cap;
   } ccc_core_state_type;

   ccc_core_state_type st_reg, st_next;
   logic idx_lvl, idx_ev, step_ev, wrap, own_load, pair_load;

   if (CORE_W < 2) begin : g_chk
      $error("ccc_core width must be at least two");
   end

   // Event decode; software index source ignores the pin
   assign idx_lvl = indx_soft_i ? 1'b0 : index_i;
   assign idx_ev = indx_neg_i ? (st_reg.idx_prev & ~idx_lvl) : (~st_reg.idx_prev & idx_lvl);
   assign step_ev = step_i & ~st_reg.step_prev & (~gate_by_index_i | idx_lvl);
   assign wrap = step_ev & (&st_reg.count);
   // Codes 2 and 3 on an A counter match neither term, so loading stays off
   assign own_load = (load_sel_i == CCC_LOAD_ON_OWN_INDEX && idx_ev)
      || (load_sel_i == CCC_LOAD_ON_OWN_OVERFLOW && wrap);
   assign pair_load = IS_B && load_sel_i == CCC_LOAD_ON_PAIRED_OVERFLOW && pair_ovf_i;

   // Next state: load beats counting in the trigger cycle
   always_comb begin
      st_next = st_reg;
      st_next.idx_prev = idx_lvl;
      st_next.step_prev = step_i;
      st_next.ovf = wrap;
      if (step_ev) begin
         st_next.count = CORE_W'(st_reg.count + 1'b1);
      end
      if (pair_load) begin
         st_next.latch = st_reg.count;
         st_next.count = '0;
      end else if (own_load) begin
         st_next.count = preload_i;
      end
      // New events win over a clear in the same cycle
      st_next.idx_cap = (st_reg.idx_cap & ~cap_clr_i) | idx_ev;
      st_next.ovf_cap = (st_reg.ovf_cap & ~cap_clr_i) | wrap;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign ovf_o = st_reg.ovf;
   assign idx_cap_o = st_reg.idx_cap;
   assign ovf_cap_o = st_reg.ovf_cap;
   assign count_o = st_reg.count;
   assign latch_o = st_reg.latch;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   load_take_a: assert property (own_load |=> count_o == $past(preload_i))
      else $error("core did not take preload on trigger");
   paired_clear_a: assert property (pair_load |=> count_o == '0 && latch_o == $past(count_o))
      else $error("paired overflow did not latch and clear");
   a_disabled_a: assert property (!IS_B && load_sel_i[1] && !step_ev |=> $stable(count_o))
      else $error("disabled load code changed the core");
   core_hold_a: assert property (!own_load && !pair_load && !step_ev |=> $stable(count_o))
      else $error("core changed without trigger");
endmodule

// file: rtl/ccc_top.sv
// Wishbone register front end and configuration store for six counter channels
`timescale 1ns/10ps
module ccc_top (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Counter pins, one bit per channel
   input wire logic [ccc_pkg::CCC_CHANNELS-1:0] index_i,
   input wire logic [ccc_pkg::CCC_CHANNELS-1:0] step_i,
   // Error status
   output logic illegal_parameter_flag_o
);
   import ccc_pkg::*;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
      logic [2:0] chan;
      logic err;
      logic [CCC_CHANNELS-1:0][15:0] cfg;
      logic [CCC_PAIRS-1:0][1:0] latch_sel;
      logic [CCC_CHANNELS-1:0][CCC_CORE_W-1:0] preload;
      logic [CCC_CHANNELS-1:0] cap_clr;
   } ccc_top_state_type;

   ccc_top_state_type st_reg, st_next;

   logic req, wr, rd;
   logic [31:0] wd;
   logic [15:0] wd16;
   logic [2:0] ch;
   logic mode_ok;
   logic [15:0] mode_rb;
   logic [2*CCC_CHANNELS-1:0] pins_s;
   logic [CCC_CHANNELS-1:0] ovf_w, idx_cap_w, ovf_cap_w;
   logic [CCC_CHANNELS-1:0][CCC_CORE_W-1:0] count_w, latch_w;

   // True for channels 3 to 5, the B half of each pair
   function automatic logic is_b(input logic [2:0] c);
      return c >= CCC_FIRST_B;
   endfunction

   // Pair index of a channel
   function automatic logic [1:0] pair_of(input logic [2:0] c);
      return is_b(c) ? 2'(c - CCC_FIRST_B) : c[1:0];
   endfunction

   // Byte lanes not selected count as zero
   function automatic logic [31:0] lane_mask(input logic [31:0] d, input logic [3:0] s);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[8*i +: 8] = s[i] ? d[8*i +: 8] : 8'h00;
      end
      return m;
   endfunction

   // Extender clock source exists only on B counters
   function automatic logic mode_legal(input logic [15:0] w, input logic b);
      return b || w[CCC_F_CLKSRC +: 2] != CCC_CLKSRC_EXTENDER;
   endfunction

   // Apply forced values and defaults to a written mode word
   function automatic logic [15:0] mode_fix(input logic [15:0] w);
      logic [15:0] f;
      f = w & CCC_MODE_MASK;
      f[CCC_F_INTSRC +: 2] = CCC_IRQ_SOURCE_OFF;
      f[CCC_F_LATCH +: 2] = 2'h0;
      if (f[CCC_F_INDXSRC]) begin
         f[CCC_F_INDXPOL] = 1'b0;
      end
      // Only counter mode may multiply the clock
      if (f[CCC_F_CLKSRC + 1] && !f[CCC_F_CLKMULT + 1]) begin
         f[CCC_F_CLKMULT +: 2] = CCC_CLKMULT_1X;
      end
      return f;
   endfunction

   // Pin inputs cross into the clock domain here
   ccc_sync #(
      .W(2 * CCC_CHANNELS)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i({step_i, index_i}),
      .sync_o(pins_s)
   );

   // One core per channel; A cores see their own overflow on the pair input and ignore it
   for (genvar g = 0; g < CCC_CHANNELS; g++) begin : g_core
      ccc_core #(
         .CORE_W(CCC_CORE_W),
         .IS_B(g >= CCC_PAIRS)
      ) u_core (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .index_i(pins_s[g]),
         .step_i(pins_s[CCC_CHANNELS + g]),
         .indx_soft_i(st_reg.cfg[g][CCC_F_INDXSRC]),
         .indx_neg_i(st_reg.cfg[g][CCC_F_INDXPOL]),
         .gate_by_index_i(st_reg.cfg[g][CCC_F_CLKENAB]),
         .load_sel_i(st_reg.cfg[g][CCC_F_LOADSRC +: 2]),
         .preload_i(st_reg.preload[g]),
         .pair_ovf_i(ovf_w[g % CCC_PAIRS]),
         .cap_clr_i(st_reg.cap_clr[g]),
         .ovf_o(ovf_w[g]),
         .idx_cap_o(idx_cap_w[g]),
         .ovf_cap_o(ovf_cap_w[g]),
         .count_o(count_w[g]),
         .latch_o(latch_w[g])
      );
   end

   // Bus decode; a request is served once, in the cycle before ack rises
   assign req = wb_cyc_i & wb_stb_i & ~st_reg.ack;
   assign wr = req & wb_we_i;
   assign rd = req & ~wb_we_i;
   assign wd = lane_mask(wb_dat_i, wb_sel_i);
   assign wd16 = wd[15:0];
   assign ch = st_reg.chan;
   assign mode_ok = mode_legal(wd16, is_b(ch));
   assign mode_rb = st_reg.cfg[ch] | (16'(st_reg.latch_sel[pair_of(ch)]) << CCC_F_LATCH);

   // Register writes and read data
   always_comb begin
      st_next = st_reg;
      st_next.ack = wb_cyc_i & wb_stb_i & ~st_reg.ack;
      st_next.cap_clr = '0;
      st_next.dat = '0;
      if (wr) begin
         unique case (wb_adr_i)
            CCC_OFS_CHAN: begin
               if (wd16 > CCC_MAX_CHAN) begin
                  st_next.err = 1'b1;
               end else begin
                  st_next.chan = wd16[2:0];
               end
            end
            CCC_OFS_MODE: begin
               if (mode_ok) begin
                  st_next.cfg[ch] = mode_fix(wd16);
                  st_next.cap_clr[ch] = 1'b1;
               end else begin
                  st_next.err = 1'b1;
               end
            end
            CCC_OFS_GATE: begin
               st_next.cfg[ch][CCC_F_CLKENAB] = (wd16 != 16'h0000) ?
                  CCC_COUNT_GATE_BY_INDEX : CCC_COUNT_GATE_ALWAYS;
            end
            CCC_OFS_PRELOAD: begin
               st_next.preload[ch] = wd[CCC_CORE_W-1:0];
            end
            CCC_OFS_LOADTRIG: begin
               if (wd16 > CCC_MAX_LOAD) begin
                  st_next.err = 1'b1;
               end else begin
                  st_next.cfg[ch][CCC_F_LOADSRC +: 2] = wd16[1:0];
               end
            end
            CCC_OFS_STATUS: begin
               // Write one to clear; no hardware set can fall in the same cycle
               if (wd[CCC_ST_ERR]) begin
                  st_next.err = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
      if (rd) begin
         unique case (wb_adr_i)
            CCC_OFS_CHAN: st_next.dat = 32'(st_reg.chan);
            CCC_OFS_MODE: st_next.dat = 32'(mode_rb);
            CCC_OFS_GATE: st_next.dat = 32'(st_reg.cfg[ch][CCC_F_CLKENAB]);
            CCC_OFS_PRELOAD: st_next.dat = 32'(st_reg.preload[ch]);
            CCC_OFS_LOADTRIG: st_next.dat = 32'(st_reg.cfg[ch][CCC_F_LOADSRC +: 2]);
            CCC_OFS_STATUS: begin
               st_next.dat = (32'(st_reg.err) << CCC_ST_ERR)
                  | (32'(idx_cap_w) << CCC_ST_IDX)
                  | (32'(ovf_cap_w) << CCC_ST_OVF);
            end
            CCC_OFS_COUNT: st_next.dat = 32'(count_w[ch]);
            CCC_OFS_LATCH: st_next.dat = 32'(latch_w[ch]);
            default: st_next.dat = '0;
         endcase
      end
   end

   // State register; the latch select is only ever reset, never written here
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= '0;
         st_reg.cfg <= {CCC_CHANNELS{CCC_MODE_RESET}};
         st_reg.chan <= CCC_CHAN_RESET;
         st_reg.latch_sel <= {CCC_PAIRS{CCC_LATCH_RESET}};
      end else begin
         st_reg <= st_next;
      end
   end

   assign wb_dat_o = st_reg.dat;
   assign wb_ack_o = st_reg.ack;
   assign illegal_parameter_flag_o = st_reg.err;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_mode_read;
      rd && wb_adr_i == CCC_OFS_MODE;
   endsequence

   sequence s_mode_answer;
      wb_ack_o && wb_dat_o[15:0] == $past(mode_rb) ##1 !wb_ack_o;
   endsequence

   chan_guard_a: assert property (
      wr && wb_adr_i == CCC_OFS_CHAN && wd16 > CCC_MAX_CHAN |=> st_reg.err && $stable(st_reg.chan))
      else $error("illegal channel accepted");
   mode_clear_a: assert property (
      wr && wb_adr_i == CCC_OFS_MODE && mode_ok
      |=> st_reg.cap_clr[$past(ch)] && st_reg.cfg[$past(ch)][CCC_F_INTSRC +: 2] == CCC_IRQ_SOURCE_OFF)
      else $error("mode write left events or interrupt source");
   latch_keep_a: assert property (wr |=> $stable(st_reg.latch_sel))
      else $error("latch select changed by a write");
   mode_reject_a: assert property (
      wr && wb_adr_i == CCC_OFS_MODE && !mode_ok |=> $stable(st_reg.cfg) && st_reg.err)
      else $error("illegal mode write altered configuration");
   mult_default_a: assert property (
      wr && wb_adr_i == CCC_OFS_MODE && mode_ok && wd16[CCC_F_CLKSRC + 1]
      |=> st_reg.cfg[$past(ch)][CCC_F_CLKMULT + 1])
      else $error("multiplier not defaulted outside counter mode");
   readback_a: assert property (s_mode_read |=> s_mode_answer)
      else $error("mode readback mismatch");
   gate_write_a: assert property (
      wr && wb_adr_i == CCC_OFS_GATE
      |=> st_reg.cfg[$past(ch)][CCC_F_CLKENAB] == ($past(wd16) != 16'h0000))
      else $error("count gate write decoded wrongly");
   preload_a: assert property (
      wr && wb_adr_i == CCC_OFS_PRELOAD |=> st_reg.preload[$past(ch)] == $past(wd[23:0]))
      else $error("preload not stored from low bits");
   trig_illegal_a: assert property (
      wr && wb_adr_i == CCC_OFS_LOADTRIG && wd16 > CCC_MAX_LOAD
      |=> st_reg.err && $stable(st_reg.cfg))
      else $error("illegal load trigger accepted");
   trig_legal_a: assert property (
      wr && wb_adr_i == CCC_OFS_LOADTRIG && wd16 <= CCC_MAX_LOAD
      |=> st_reg.cfg[$past(ch)][CCC_F_LOADSRC +: 2] == $past(wd16[1:0]))
      else $error("load trigger not stored");

   // Bus handshake: one ack per request, data only beside a read ack
   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   ack_once_a: assert property (req |=> s_ack_pulse)
      else $error("ack not a single pulse after request");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == '0)
      else $error("read data shown outside an ack");
   write_dat_a: assert property (wr |=> wb_ack_o && wb_dat_o == '0)
      else $error("write answered with data");
   flag_clear_a: assert property (
      wr && wb_adr_i == CCC_OFS_STATUS && wd[CCC_ST_ERR] |=> !st_reg.err)
      else $error("error flag not cleared by status write");
   err_sticky_a: assert property (
      st_reg.err && !(wr && wb_adr_i == CCC_OFS_STATUS && wd[CCC_ST_ERR]) |=> st_reg.err)
      else $error("error flag dropped without a clear");

   // Stores; these catch a lost or shifted field, not only a wrong default
   mode_trig_a: assert property (
      wr && wb_adr_i == CCC_OFS_MODE && mode_ok
      |=> st_reg.cfg[$past(ch)][CCC_F_LOADSRC +: 2] == $past(wd16[CCC_F_LOADSRC +: 2])
      && st_reg.cfg[$past(ch)][CCC_F_CLKENAB] == $past(wd16[CCC_F_CLKENAB]))
      else $error("mode write lost load trigger or count gate");
   soft_pol_a: assert property (
      wr && wb_adr_i == CCC_OFS_MODE && mode_ok && wd16[CCC_F_INDXSRC]
      |=> !st_reg.cfg[$past(ch)][CCC_F_INDXPOL])
      else $error("index polarity not forced on soft source");
   chan_take_a: assert property (
      wr && wb_adr_i == CCC_OFS_CHAN && wd16 <= CCC_MAX_CHAN
      |=> st_reg.chan == $past(wd16[2:0]))
      else $error("legal channel not selected");
   chan_range_a: assert property (16'(st_reg.chan) <= CCC_MAX_CHAN)
      else $error("selected channel out of range");
endmodule

// file: testbench/tb_top.sv
// Self-checking testbench for the counter channel configuration block
`timescale 1ns/10ps
`define CHK(g, e) begin \
   samples_checked++; \
   if ((g) !== (e)) begin \
      bad_count++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); \
   end \
end
module tb_top;
   import ccc_pkg::*;
   typedef struct {
      logic [7:0] adr;
      logic [31:0] wdat;
      logic [7:0] radr;
      logic [31:0] rexp;
      logic fexp;
   } ccc_row_type;
   // Bench signals; every DUT input given a value at time zero
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h00000000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [5:0] index_i = 6'h00;
   logic [5:0] step_i = 6'h00;
   logic illegal_parameter_flag_o;
   logic [31:0] rd;
   int bad_count = 0;
   int samples_checked = 0;
   // Write, readback register, expected readback, expected error flag
   ccc_row_type rows [22] = '{
      '{CCC_OFS_CHAN, 32'h5, CCC_OFS_CHAN, 32'h5, 1'b0},
      '{CCC_OFS_CHAN, 32'h6, CCC_OFS_CHAN, 32'h5, 1'b1},
      '{CCC_OFS_CHAN, 32'hffff, CCC_OFS_CHAN, 32'h5, 1'b1},
      '{CCC_OFS_CHAN, 32'h0, CCC_OFS_CHAN, 32'h0, 1'b0},
      '{CCC_OFS_PRELOAD, 32'haabbccdd, CCC_OFS_PRELOAD, 32'h00bbccdd, 1'b0},
      '{CCC_OFS_GATE, 32'h1, CCC_OFS_GATE, 32'h1, 1'b0},
      '{CCC_OFS_GATE, 32'hffff, CCC_OFS_MODE, 32'h3030, 1'b0},
      '{CCC_OFS_GATE, 32'h0, CCC_OFS_GATE, 32'h0, 1'b0},
      '{CCC_OFS_LOADTRIG, 32'h0, CCC_OFS_LOADTRIG, 32'h0, 1'b0},
      '{CCC_OFS_LOADTRIG, 32'h1, CCC_OFS_LOADTRIG, 32'h1, 1'b0},
      '{CCC_OFS_LOADTRIG, 32'h2, CCC_OFS_LOADTRIG, 32'h2, 1'b0},
      '{CCC_OFS_LOADTRIG, 32'h3, CCC_OFS_MODE, 32'h1030, 1'b0},
      '{CCC_OFS_LOADTRIG, 32'h4, CCC_OFS_LOADTRIG, 32'h3, 1'b1},
      '{CCC_OFS_LOADTRIG, 32'hffff, CCC_OFS_MODE, 32'h1030, 1'b1},
      '{CCC_OFS_MODE, 32'h2013, CCC_OFS_MODE, 32'h2010, 1'b0},
      '{CCC_OFS_MODE, 32'h2013, CCC_OFS_GATE, 32'h1, 1'b0},
      '{CCC_OFS_MODE, 32'h000c, CCC_OFS_MODE, 32'h0000, 1'b0},
      '{CCC_OFS_MODE, 32'h00c0, CCC_OFS_MODE, 32'h0040, 1'b0},
      '{CCC_OFS_MODE, 32'h0200, CCC_OFS_MODE, 32'h1200, 1'b0},
      '{CCC_OFS_MODE, 32'h0300, CCC_OFS_MODE, 32'h1200, 1'b1},
      '{CCC_OFS_CHAN, 32'h3, CCC_OFS_MODE, 32'h1030, 1'b0},
      '{CCC_OFS_MODE, 32'h0320, CCC_OFS_MODE, 32'h1320, 1'b0}
   };

   // Free-running clock, 4 ns period
   always #2 clk_i = ~clk_i;

   ccc_top i_ccc_top (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .index_i(index_i),
      .step_i(step_i),
      .illegal_parameter_flag_o(illegal_parameter_flag_o)
   );

   // Counts, then the verdict; the only place the run ends
   task wrap_up();
      $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // One classic cycle; ack is read before the edge's own updates land
   task wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hf;
      wb_dat_i <= dat;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, wb_ack_o, 1'b1);
         wrap_up();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      // Strobe stays low for at least two cycles before the next request
      @(posedge clk_i);
   endtask

   task wr(input logic [7:0] adr, input logic [31:0] dat);
      wb_cycle(1'b1, adr, dat);
   endtask

   task chk_rd(input logic [7:0] adr, input logic [31:0] exp);
      wb_cycle(1'b0, adr, 32'h00000000);
      `CHK(rd, exp)
   endtask

   // Pins are synchronised, so each pulse is held well past the two flops
   task pulse(input int ch, input logic is_index);
      @(posedge clk_i);
      if (is_index) index_i[ch] <= 1'b1;
      else step_i[ch] <= 1'b1;
      repeat (4) @(posedge clk_i);
      if (is_index) index_i[ch] <= 1'b0;
      else step_i[ch] <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask

   task do_reset();
      rst_i <= 1'b1;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask

   // Watchdog against a hang anywhere
   initial begin
      repeat (50000) @(posedge clk_i);
      bad_count++;
      wrap_up();
   end

   initial begin
      do_reset();
      // Table of single writes with readback and flag
      foreach (rows[i]) begin
         wr(rows[i].adr, rows[i].wdat);
         chk_rd(rows[i].radr, rows[i].rexp);
         `CHK(illegal_parameter_flag_o, rows[i].fexp)
         if (rows[i].fexp) begin
            wr(CCC_OFS_STATUS, 32'h1);
            `CHK(illegal_parameter_flag_o, 1'b0)
         end
      end
      $display("test table done");
      // Mid-run reset brings back the reset state
      do_reset();
      chk_rd(CCC_OFS_MODE, 32'h1030);
      chk_rd(CCC_OFS_CHAN, 32'h0);
      chk_rd(CCC_OFS_PRELOAD, 32'h0);
      chk_rd(8'h20, 32'h0);
      `CHK(illegal_parameter_flag_o, 1'b0)
      $display("test reset done");
      // Preload waits for the index trigger; mode write clears captures
      wr(CCC_OFS_MODE, 32'h0000);
      wr(CCC_OFS_PRELOAD, 32'h00123456);
      chk_rd(CCC_OFS_COUNT, 32'h0);
      pulse(0, 1'b1);
      chk_rd(CCC_OFS_COUNT, 32'h00123456);
      wb_cycle(1'b0, CCC_OFS_STATUS, 32'h0);
      `CHK(rd[8], 1'b1)
      wr(CCC_OFS_MODE, 32'h0000);
      wb_cycle(1'b0, CCC_OFS_STATUS, 32'h0);
      `CHK(rd[8], 1'b0)
      $display("test index load done");
      // B on paired overflow: A wraps, B latches its count and clears
      wr(CCC_OFS_CHAN, 32'h3);
      wr(CCC_OFS_MODE, 32'h0020);
      pulse(3, 1'b0);
      pulse(3, 1'b0);
      wr(CCC_OFS_CHAN, 32'h0);
      wr(CCC_OFS_PRELOAD, 32'h00fffffe);
      pulse(0, 1'b1);
      wr(CCC_OFS_LOADTRIG, 32'h1);
      wr(CCC_OFS_PRELOAD, 32'h00000100);
      pulse(0, 1'b0);
      chk_rd(CCC_OFS_COUNT, 32'h00ffffff);
      pulse(0, 1'b0);
      chk_rd(CCC_OFS_COUNT, 32'h00000100);
      wb_cycle(1'b0, CCC_OFS_STATUS, 32'h0);
      `CHK(rd[16], 1'b1)
      wr(CCC_OFS_CHAN, 32'h3);
      chk_rd(CCC_OFS_COUNT, 32'h0);
      chk_rd(CCC_OFS_LATCH, 32'h2);
      $display("test overflow load done");
      // Gate by index: steps count only while index is high
      wr(CCC_OFS_CHAN, 32'h0);
      wr(CCC_OFS_MODE, 32'h2030);
      pulse(0, 1'b0);
      chk_rd(CCC_OFS_COUNT, 32'h00000100);
      @(posedge clk_i);
      index_i[0] <= 1'b1;
      pulse(0, 1'b0);
      pulse(0, 1'b0);
      chk_rd(CCC_OFS_COUNT, 32'h00000102);
      @(posedge clk_i);
      index_i[0] <= 1'b0;
      $display("test count gate done");
      wrap_up();
   end
endmodule
